// ==== core/cfs_fault_status.sv ====
// fault status capture, fault address loading and handler control
`timescale 1ns/10ps
module cfs_fault_status (
	input wire logic ref_clk, // 10 MHz clock
	input wire logic reset, // synchronous, active high
	input wire logic [cfs_pkg::ADDR_W-1:0] reg_addr, // byte address
	input wire logic [1:0] reg_size, // byte, halfword or word
	input wire logic [31:0] reg_wdata, // write data, lane aligned
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic ev_fetch_xn, // fetch from no-execute region
	input wire logic ev_data_viol, // load/store permission violation
	input wire logic [31:0] ev_data_addr, // attempted data address
	input wire logic ev_mem_unstack, // unstacking access violation
	input wire logic ev_mem_stack, // stacking access violation
	input wire logic ev_mem_lazy, // lazy fp access violation
	input wire logic ev_ibus_issue, // prefetch-errored instruction issued
	input wire logic ev_precise, // precise data bus error
	input wire logic [31:0] ev_bus_addr, // faulting bus address
	input wire logic ev_imprecise, // imprecise data bus error
	input wire logic ev_bus_unstack, // unstacking bus fault
	input wire logic ev_bus_stack, // stacking bus fault
	input wire logic ev_bus_lazy, // lazy fp bus fault
	input wire logic ev_undef, // undecodable instruction executed
	input wire logic ev_state, // illegal execution state use
	input wire logic ev_exception_return_value, // illegal exception return load
	input wire logic ev_coproc, // coprocessor access attempted
	input wire logic ev_unaligned, // unaligned single access
	input wire logic ev_unaligned_multi, // unaligned multiple/doubleword
	input wire logic ev_div_zero, // divide with zero divisor
	input wire logic [3:0] cur_priority, // current execution priority
	input wire logic [3:0] bus_priority, // bus fault handler priority
	input wire logic handler_return, // core returned from a handler
	output logic hard_fault_req, // one-cycle escalation to hard fault
	output logic mem_fault_req, // memory management fault taken
	output logic bus_fault_req, // bus fault taken
	output logic usage_fault_req, // usage fault taken
	output logic stack_return_to_fault, // stacked pc is faulting instr
	output logic stack_adjust_sp, // stacking still adjusts sp
	output logic mem_fault_active // memory fault handler active
);
	import cfs_pkg::*;

	cfs_state_t cur, nxt;
	logic [31:0] set_mask;
	logic [31:0] wmask;
	logic [31:0] wlane;
	logic mem_ev, bus_ev, usg_ev, imprec_held;

	//////////////////////////////////////////////////////////////////////
	// lane mask of an access; decoded for status, control and config
	function automatic logic [31:0] lane_mask(input logic [7:0] a, input logic [1:0] sz);
		logic [31:0] m;
		m = 32'h0000_0000;
		case (sz)
			SZ_BYTE: m = 32'h0000_00FF << {a[1:0], 3'h0};
			SZ_HALF: m = a[1] ? 32'hFFFF_0000 : 32'h0000_FFFF;
			default: m = 32'hFFFF_FFFF;
		endcase
		return m;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		wmask = lane_mask(reg_addr, reg_size);
		// byte and halfword data sits in its own lanes
		wlane = reg_wdata & wmask;
		set_mask = 32'h0000_0000;
		set_mask[B_IACC] = ev_fetch_xn;
		set_mask[B_DACC] = ev_data_viol;
		set_mask[B_MUNSTK] = ev_mem_unstack;
		set_mask[B_MSTK] = ev_mem_stack;
		set_mask[B_MLSP] = ev_mem_lazy;
		set_mask[B_IBUS] = ev_ibus_issue;
		set_mask[B_PREC] = ev_precise;
		set_mask[B_IMPREC] = ev_imprecise;
		set_mask[B_UNSTK] = ev_bus_unstack;
		set_mask[B_STK] = ev_bus_stack;
		set_mask[B_LSP] = ev_bus_lazy;
		set_mask[B_UNDEF] = ev_undef;
		set_mask[B_INVST] = ev_state & ~ev_undef;
		set_mask[B_INVALID_PC_LOAD_FAULT] = ev_exception_return_value;
		set_mask[B_NO_COPROCESSOR_FAULT] = ev_coproc;
		set_mask[B_UNAL] = (ev_unaligned & cur.config_r[G_UNALIGN_TRAP]) | ev_unaligned_multi;
		set_mask[B_DIVZ] = ev_div_zero & cur.config_r[G_DIV0_TRAP];
		mem_ev = |set_mask[7:0];
		bus_ev = |set_mask[15:8];
		usg_ev = |set_mask[25:16];
		// imprecise error waits while a higher priority handler runs
		imprec_held = ev_imprecise & (cur_priority < bus_priority);

		nxt = cur;
		nxt.prio_cur = cur_priority;
		nxt.prio_bus = bus_priority;
		// write one to clear; new events win over the clear
		if (reg_wr && hit(reg_addr, OFF_STATUS))
			nxt.status = cur.status & ~wlane;
		nxt.status = (nxt.status | set_mask) & STATUS_MASK;
		if (ev_data_viol) begin
			nxt.mem_addr = ev_data_addr;
			nxt.status[B_MVALID] = 1'b1;
		end
		if (ev_precise) begin
			nxt.bus_addr = ev_bus_addr;
			nxt.status[B_BVALID] = 1'b1;
		end else if (ev_data_viol)
			nxt.status[B_BVALID] = 1'b0;
		if (reg_wr && hit(reg_addr, OFF_CONTROL))
			nxt.control = (cur.control & ~(wmask & CONTROL_MASK)) | (wlane & CONTROL_MASK);
		if (reg_wr && hit(reg_addr, OFF_CONFIG))
			nxt.config_r = (cur.config_r & ~(wmask & CONFIG_MASK)) | (wlane & CONFIG_MASK);
		if (reg_wr && hit(reg_addr, OFF_ESCALATE))
			nxt.escalate = cur.escalate & ~wlane;
		if (mem_ev & ~cur.control[C_MEM_ENA])
			nxt.escalate[0] = 1'b1;
		if (bus_ev & ~cur.control[C_BUS_ENA])
			nxt.escalate[0] = 1'b1;
		if (usg_ev & ~cur.control[C_USG_ENA])
			nxt.escalate[0] = 1'b1;
		if (mem_ev & cur.control[C_MEM_ENA])
			nxt.control[C_MEM_PEND] = 1'b1;
		if ((bus_ev & ~imprec_held | set_mask[B_PREC]) & cur.control[C_BUS_ENA])
			nxt.control[C_BUS_PEND] = 1'b1;
		if (ev_imprecise & imprec_held & cur.control[C_BUS_ENA])
			nxt.control[C_BUS_PEND] = 1'b1;
		if (usg_ev & cur.control[C_USG_ENA])
			nxt.control[C_USG_PEND] = 1'b1;

		nxt.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (1'b1)
				hit(reg_addr, OFF_STATUS): nxt.rdata = cur.status & STATUS_MASK & wmask;
				hit(reg_addr, OFF_CONTROL): nxt.rdata = cur.control & wmask;
				hit(reg_addr, OFF_CONFIG): nxt.rdata = cur.config_r & wmask;
				hit(reg_addr, OFF_MEM_ADDR): nxt.rdata = cur.mem_addr;
				hit(reg_addr, OFF_BUS_ADDR): nxt.rdata = cur.bus_addr;
				hit(reg_addr, OFF_ESCALATE): nxt.rdata = cur.escalate;
				default: nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cur.status <= STATUS_RESET;
			cur.control <= CONTROL_RESET;
			cur.config_r <= 32'h0000_0000;
			cur.mem_addr <= 32'h0000_0000;
			cur.bus_addr <= 32'h0000_0000;
			cur.escalate <= 32'h0000_0000;
			cur.rdata <= 32'h0000_0000;
			cur.prio_cur <= 4'h0;
			cur.prio_bus <= 4'h0;
		end else begin
			cur <= nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	assign reg_rdata = cur.rdata;
	assign hard_fault_req = (mem_ev & ~cur.control[C_MEM_ENA]) | (bus_ev & ~cur.control[C_BUS_ENA])
		| (usg_ev & ~cur.control[C_USG_ENA]);
	assign mem_fault_req = mem_ev & cur.control[C_MEM_ENA];
	// held imprecise error is released by a handler return
	assign bus_fault_req = cur.control[C_BUS_ENA] & ((bus_ev & ~imprec_held)
		| (handler_return & cur.control[C_BUS_PEND] & (cur.prio_cur >= cur.prio_bus)));
	assign usage_fault_req = usg_ev & cur.control[C_USG_ENA];
	// stacked pc points at the faulting instruction
	assign stack_return_to_fault = ev_fetch_xn | ev_data_viol | ev_precise | ev_undef
		| (ev_state & ~ev_undef) | ev_exception_return_value | ev_div_zero;
	// unstacking faults keep sp; stacking faults still adjust it
	assign stack_adjust_sp = (ev_mem_stack | ev_bus_stack) & ~(ev_mem_unstack | ev_bus_unstack);
	assign mem_fault_active = cur.control[C_MEM_ACT];
endmodule

// ==== core/cfs_pkg.sv ====
// package: register map, field positions and encodings of the fault status logic
package cfs_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_STATUS = 8'h28;
	localparam logic [7:0] OFF_CONTROL = 8'h24;
	localparam logic [7:0] OFF_CONFIG = 8'h14;
	localparam logic [7:0] OFF_MEM_ADDR = 8'h34;
	localparam logic [7:0] OFF_BUS_ADDR = 8'h38;
	localparam logic [7:0] OFF_ESCALATE = 8'h2C;
	localparam int B_IACC = 0;
	localparam int B_DACC = 1;
	localparam int B_MUNSTK = 3;
	localparam int B_MSTK = 4;
	localparam int B_MLSP = 5;
	localparam int B_MVALID = 7;
	localparam int B_IBUS = 8;
	localparam int B_PREC = 9;
	localparam int B_IMPREC = 10;
	localparam int B_UNSTK = 11;
	localparam int B_STK = 12;
	localparam int B_LSP = 13;
	localparam int B_BVALID = 15;
	localparam int B_UNDEF = 16;
	localparam int B_INVST = 17;
	localparam int B_INVALID_PC_LOAD_FAULT = 18;
	localparam int B_NO_COPROCESSOR_FAULT = 19;
	localparam int B_UNAL = 24;
	localparam int B_DIVZ = 25;
	localparam logic [31:0] STATUS_MASK = 32'h030F_BFBB;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	// control register layout: enables 18:16, pending 15:12, active 11:0
	localparam logic [31:0] CONTROL_MASK = 32'h0007_FD8B;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam int C_MEM_ENA = 16;
	localparam int C_BUS_ENA = 17;
	localparam int C_USG_ENA = 18;
	localparam int C_USG_PEND = 12;
	localparam int C_MEM_PEND = 13;
	localparam int C_BUS_PEND = 14;
	localparam int C_MEM_ACT = 0;
	localparam int C_BUS_ACT = 1;
	localparam int C_USG_ACT = 3;
	localparam int G_UNALIGN_TRAP = 3;
	localparam int G_DIV0_TRAP = 4;
	localparam logic [31:0] CONFIG_MASK = 32'h0000_0018;
	// byte size codes of the access port
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	typedef struct packed {
		logic [31:0] status;
		logic [31:0] control;
		logic [31:0] config_r;
		logic [31:0] mem_addr;
		logic [31:0] bus_addr;
		logic [31:0] escalate;
		logic [31:0] rdata;
		logic [3:0] prio_cur;
		logic [3:0] prio_bus;
	} cfs_state_t;
endpackage

// ==== tb/cfs_checker_sva.sv ====
// checker: port-level behaviour of the fault status logic
`timescale 1ns/10ps
module cfs_checker (
	input wire logic ref_clk, // clock
	input wire logic reset, // sync reset
	input wire logic [cfs_pkg::ADDR_W-1:0] reg_addr, // address
	input wire logic [1:0] reg_size, // size
	input wire logic reg_rd, // read strobe
	input wire logic [31:0] reg_rdata, // read data
	input wire logic ev_fetch_xn, // event
	input wire logic ev_data_viol, // event
	input wire logic ev_mem_unstack, // event
	input wire logic ev_precise, // event
	input wire logic ev_coproc, // event
	input wire logic ev_unaligned_multi // event
);
	import cfs_pkg::*;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// whole status word read in the cycle after an event
	sequence rd_st;
		reg_rd && reg_addr == OFF_STATUS && reg_size == SZ_WORD;
	endsequence
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("idle read data");
	chk_reserved_zero: assert property (rd_st |=> (reg_rdata & ~STATUS_MASK) == 32'h0) else $error("reserved");
	chk_fetch_flag: assert property (ev_fetch_xn ##1 rd_st |=> reg_rdata[B_IACC]) else $error("fetch flag");
	chk_data_flag: assert property (ev_data_viol ##1 rd_st |=> reg_rdata[B_DACC] && reg_rdata[B_MVALID])
		else $error("data flag");
	chk_unstack_flag: assert property (ev_mem_unstack ##1 rd_st |=> reg_rdata[B_MUNSTK]) else $error("unstack");
	chk_precise_flag: assert property (ev_precise ##1 rd_st |=> reg_rdata[B_PREC] && reg_rdata[B_BVALID])
		else $error("precise flag");
	chk_coproc_flag: assert property (ev_coproc ##1 rd_st |=> reg_rdata[B_NO_COPROCESSOR_FAULT]) else $error("coproc flag");
	chk_multi_flag: assert property (ev_unaligned_multi ##1 rd_st |=> reg_rdata[B_UNAL]) else $error("multi");
endmodule
bind cfs_fault_status cfs_checker cfs_checker_i (.ref_clk, .reset, .reg_addr, .reg_size, .reg_rd, .reg_rdata,
	.ev_fetch_xn, .ev_data_viol, .ev_mem_unstack, .ev_precise, .ev_coproc, .ev_unaligned_multi);

// ==== tb/cfs_core_model.sv ====
// partner model: core fault event source
`timescale 1ns/10ps
module cfs_core_model (
	input wire logic ref_clk, // core clock
	input wire logic [4:0] cmd, // event index, above 18 idle
	input wire logic [31:0] cmd_addr, // address sent with event
	output logic [18:0] ev = 19'h0, // one-cycle pulses
	output logic [31:0] addr = 32'h0 // fault address
);
	// address scrambled between events so a stale value never looks fresh
	always @(posedge ref_clk) begin
		ev <= (cmd < 5'h13) ? 19'h1 << cmd : 19'h0;
		addr <= (cmd < 5'h13) ? cmd_addr : ~addr;
	end
endmodule

// ==== tb/tb_top.sv ====
// testbench: register access tasks and fault event sequences
`timescale 1ns/10ps
module tb_top;
	import cfs_pkg::*;
	logic ref_clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, hf, hard_fault_req;
	logic [7:0] reg_addr = 8'h0;
	logic [1:0] reg_size = 2'h2;
	logic [4:0] cmd = 5'h1F;
	logic [18:0] ev;
	logic [31:0] reg_wdata = 32'h0, cmd_addr = 32'h0, reg_rdata, ev_addr, rd;
	logic [4:0] fq;
	logic mfr, bfr, ufr, srf, sas, mfa;
	logic [31:0] flag [18] = '{32'h1, 32'h82, 32'h8, 32'h10, 32'h20, 32'h100, 32'h8200, 32'h400, 32'h800, 32'h1000,
		32'h2000, 32'h10000, 32'h20000, 32'h40000, 32'h80000, 32'h1000000, 32'h1000000, 32'h2000000};
	int bad_count = 0, checks = 0, j;
	always #50 ref_clk = ~ref_clk;
	cfs_core_model cfs_core_model_i (.ref_clk(ref_clk), .cmd(cmd), .cmd_addr(cmd_addr), .ev(ev), .addr(ev_addr));
	cfs_fault_status cfs_fault_status_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_size(reg_size),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_fetch_xn(ev[0]),
		.ev_data_viol(ev[1]), .ev_data_addr(ev_addr), .ev_mem_unstack(ev[2]), .ev_mem_stack(ev[3]), .ev_mem_lazy(ev[4]),
		.ev_ibus_issue(ev[5]), .ev_precise(ev[6]), .ev_bus_addr(ev_addr), .ev_imprecise(ev[7]), .ev_bus_unstack(ev[8]),
		.ev_bus_stack(ev[9]), .ev_bus_lazy(ev[10]), .ev_undef(ev[11]), .ev_state(ev[12]), .ev_exception_return_value(ev[13]),
		.ev_coproc(ev[14]), .ev_unaligned(ev[15]), .ev_unaligned_multi(ev[16]), .ev_div_zero(ev[17]),
		.cur_priority(4'h0), .bus_priority(4'h0), .handler_return(ev[18]), .hard_fault_req(hard_fault_req),
		.mem_fault_req(mfr), .bus_fault_req(bfr), .usage_fault_req(ufr), .stack_return_to_fault(srf),
		.stack_adjust_sp(sas), .mem_fault_active(mfa));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		bad_count += int'(got !== exp);
		if (got !== exp)
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] s, input logic [31:0] d);
		{reg_wr, reg_rd, reg_addr, reg_size, reg_wdata} <= {w, !w, a, s, d};
		@(posedge ref_clk);
		{reg_wr, reg_rd} <= 2'h0;
		#1 rd = reg_rdata;
		@(posedge ref_clk);
	endtask
	task automatic fire(input logic [4:0] i, input logic [31:0] a);
		{cmd, cmd_addr} <= {i, a};
		@(posedge ref_clk);
		cmd <= 5'h1F;
		#1 hf = hard_fault_req;
		fq = {mfr, bfr, ufr, srf, sas};
		@(posedge ref_clk);
	endtask
	task automatic give_verdict();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'h0;
		@(posedge ref_clk);
		acc(1'h0, 8'hF0, SZ_WORD, 32'h0);
		cmp(rd, 32'h0);
		// trap enables off for the first pass, on for the last two events
		for (int k = 0; k < 20; k++) begin
			if (k == 18) acc(1'h1, OFF_CONFIG, SZ_WORD, 32'h18);
			j = k < 18 ? k : 2 * k - 21;
			fire(5'(j), 32'h0);
			if (k < 2) cmp(hf, 32'h1);
			acc(1'h0, OFF_STATUS, SZ_WORD, 32'h0);
			cmp(rd, (j == k && j % 2 && j > 14) ? 32'h0 : flag[j]);
			acc(1'h1, OFF_STATUS, SZ_WORD, 32'hFFFF_FFFF);
		end
		fire(5'h7, 32'h0);
		fire(5'h6, 32'h2000_1004);
		fire(5'h1, 32'h2000_2008);
		acc(1'h0, OFF_STATUS, SZ_WORD, 32'h0);
		cmp(rd, 32'h682);
		acc(1'h0, OFF_MEM_ADDR, SZ_WORD, 32'h0);
		cmp(rd, 32'h2000_2008);
		acc(1'h0, OFF_BUS_ADDR, SZ_WORD, 32'h0);
		cmp(rd, 32'h2000_1004);
		acc(1'h1, 8'h29, SZ_BYTE, 32'h0000_0200);
		acc(1'h0, OFF_STATUS, SZ_WORD, 32'h0);
		cmp(rd, 32'h482);
		acc(1'h0, OFF_ESCALATE, SZ_WORD, 32'h0);
		cmp(rd, 32'h1);
		acc(1'h1, OFF_CONTROL, SZ_WORD, 32'h0007_0001);
		acc(1'h0, OFF_CONTROL, SZ_WORD, 32'h0);
		cmp(rd, 32'h0007_0001);
		cmp(mfa, 32'h1);
		// handlers enabled now: each fault goes to its own handler, no escalation
		fire(5'h3, 32'h0);
		cmp({hf, fq}, 32'h11);
		fire(5'h9, 32'h0);
		cmp({hf, fq}, 32'h09);
		fire(5'h11, 32'h0);
		cmp({hf, fq}, 32'h06);
		give_verdict();
	end
endmodule
